// [rtl/dnr_addr_xlate.sv]
// Combinational node number translation from a 64-bit DMA address
// to a 40-bit HT address, plus the per-node link choice.
// Assumes the caller registers the result and holds the config stable.
`timescale 1ns/100ps
`default_nettype none

module dnr_addr_xlate (
	// Incoming address.
	input wire logic [63:0] addr_i,
	// Configuration fields.
	input wire logic [3:0] node_count_mask_i,
	input wire logic [4:0] source_node_position_i,
	input wire logic [2:0] ht_side_node_position_i,
	input wire logic [15:0] per_node_link_select_i,
	// Result.
	output logic [39:0] ht_addr_o,
	output logic [3:0] node_o,
	output logic link_sel_o
);

	// Shift amounts; a source position past bit 63 simply yields node zero.
	wire [6:0] src_sh = dnr_pkg::SRC_BASE + {2'h0, source_node_position_i};
	wire [6:0] ht_sh = dnr_pkg::HT_BASE + {4'h0, ht_side_node_position_i};
	wire [63:0] mask64 = {60'h0, node_count_mask_i};

	// Pick the node, strip it from the source, then place it on the HT side.
	wire [63:0] node_all = (addr_i >> src_sh) & mask64;
	wire [63:0] stripped = addr_i & ~(mask64 << src_sh);
	wire [63:0] placed = (stripped & ~(mask64 << ht_sh)) | (node_all << ht_sh);

	// Bits above 39 cannot cross the HT link and are dropped here.
	assign ht_addr_o = placed[39:0];
	assign node_o = node_all[3:0];
	assign link_sel_o = per_node_link_select_i[node_all[3:0]];

endmodule : dnr_addr_xlate

`default_nettype wire

// [rtl/dnr_cfg_regs.sv]
// DMA node routing register and general configuration register zero,
// reached over classic Wishbone, with the DMA address translation path.
// Assumes one clock, a synchronous reset and a single Wishbone master.
//
// Overview of operation
// - Place node at HT bit 32 plus position.
// - HT position bounds per-node address range.
// - Take node at bit 36 plus source offset.
// - Node mask selects 1 to 16 nodes.
// - Bits 31, 30 gate g1 port clocks.
// - Bits 27, 26 gate g0 port clocks.
// - Bits 23, 22 gate h port clocks.
// - Bits 19, 18 gate f1 port clocks.
// - Bit 13 gates f0 port 3 clock.
// - Access enable bits allow controller access.
// - Soft reset bits hold controllers in reset.
// - Per-node bit picks HT controller one or zero.
`timescale 1ns/100ps
`default_nettype none

module dnr_cfg_regs (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// DMA path.
	input wire dnr_pkg::dnr_dma_req_type dma_req_i,
	output dnr_pkg::dnr_ht_req_type ht_req_o,
	// PCIe controller controls.
	output dnr_pkg::dnr_ctrl_type ctrl_g1_o,
	output dnr_pkg::dnr_ctrl_type ctrl_g0_o,
	output dnr_pkg::dnr_ctrl_type ctrl_h_o,
	output dnr_pkg::dnr_ctrl_type ctrl_f1_o,
	output logic ctrl_f0_port3_clock_on_o
);

	logic [31:0] xlate_q;
	logic [31:0] xlate_d;
	logic [31:0] gcz_q;
	logic [31:0] gcz_d;
	logic ack_q;
	logic ack_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	dnr_pkg::dnr_ht_req_type ht_q;
	dnr_pkg::dnr_ht_req_type ht_d;

	// Bus decode. Unmapped addresses still get an ack, reading zero.
	wire req = cyc_i & stb_i;
	wire hit_x = adr_i[15:2] == dnr_pkg::DMA_XLATE_OFS[15:2];
	wire hit_g = adr_i[15:2] == dnr_pkg::GCZ_OFS[15:2];
	wire [31:0] lane = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

	// A write lands on the edge where the master sees ack, and only then.
	wire wr_go = req & we_i & ack_q;
	wire wr_x = wr_go & hit_x;
	wire wr_g = wr_go & hit_g;

	// Every bit, reserved ones included, is plain read/write storage.
	assign xlate_d = wr_x ? ((xlate_q & ~lane) | (dat_i & lane)) : xlate_q;
	assign gcz_d = wr_g ? ((gcz_q & ~lane) | (dat_i & lane)) : gcz_q;

	// Ack rises one edge after the request and drops on the next.
	assign ack_d = req & ~ack_q;

	// Read data is captured with the ack so it stays still while ack is high.
	assign rdat_d = ~(req & ~ack_q) ? rdat_q :
		hit_x ? xlate_q :
		hit_g ? gcz_q :
		32'h00000000;

	// Configuration fields of the routing register.
	wire [15:0] pnl = xlate_q[dnr_pkg::PNL_LSB +: dnr_pkg::PNL_W];
	wire [2:0] ht_pos = xlate_q[dnr_pkg::HTPOS_LSB +: dnr_pkg::HTPOS_W];
	wire [4:0] src_pos = xlate_q[dnr_pkg::SRCPOS_LSB +: dnr_pkg::SRCPOS_W];
	wire [3:0] nmask = xlate_q[dnr_pkg::MASK_LSB +: dnr_pkg::MASK_W];

	wire [39:0] x_addr;
	wire [3:0] x_node;
	wire x_link;

	// The translator is purely combinational; its result is registered below.
	dnr_addr_xlate u_xlate (
		.addr_i(dma_req_i.addr),
		.node_count_mask_i(nmask),
		.source_node_position_i(src_pos),
		.ht_side_node_position_i(ht_pos),
		.per_node_link_select_i(pnl),
		.ht_addr_o(x_addr),
		.node_o(x_node),
		.link_sel_o(x_link)
	);

	// One pipeline stage keeps the outgoing request straight from a flop.
	// A single assignment gives the stage register input exactly one driver.
	assign ht_d = {
		dma_req_i.valid,
		x_link,
		x_node,
		x_addr
	};

	// Register and bus state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xlate_q <= dnr_pkg::DMA_XLATE_RST;
			gcz_q <= dnr_pkg::GCZ_RST;
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			xlate_q <= xlate_d;
			gcz_q <= gcz_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// Translated request stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ht_q <= '0;
		end else begin
			ht_q <= ht_d;
		end
	end

	// Outputs. The controls follow the register bits with no handshake.
	assign dat_o = rdat_q;
	assign ack_o = ack_q;
	assign ht_req_o = ht_q;
	assign ctrl_g1_o = gcz_q[dnr_pkg::G1_LSB +: 4];
	assign ctrl_g0_o = gcz_q[dnr_pkg::G0_LSB +: 4];
	assign ctrl_h_o = gcz_q[dnr_pkg::H_LSB +: 4];
	assign ctrl_f1_o = gcz_q[dnr_pkg::F1_LSB +: 4];
	assign ctrl_f0_port3_clock_on_o = gcz_q[dnr_pkg::F0_P3_BIT];

	// Checks run on the one clock and are quiet during reset.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Steps of a bus access.
	sequence s_req_open;
		req && !ack_q;
	endsequence

	sequence s_read_gcz;
		s_req_open ##0 (!we_i && hit_g);
	endsequence

	// A write lands on the edge where the master sees ack.
	sequence s_write_land;
		req && we_i && ack_q;
	endsequence

	// Ack is a single-cycle pulse that answers a request one edge later.
	a_ack_one_pulse: assert property (s_req_open |=> ack_o ##1 !ack_o)
		else $error("ack did not pulse for exactly one cycle");

	// Reading the config register returns what it holds.
	a_read_back_gcz: assert property (s_read_gcz |=> ack_o && dat_o == $past(gcz_q))
		else $error("general config read returned wrong data");

	// A full-word write is visible on the next edge.
	a_write_full_word: assert property (wr_g && sel_i == 4'hf |=> gcz_q == $past(dat_i))
		else $error("general config write not stored");

	// The g1 port clocks follow bits 31 and 30.
	a_g1_port_clocks: assert property (wr_g && sel_i[3] |=>
		ctrl_g1_o.port1_clock_on == $past(dat_i[31]) && ctrl_g1_o.port0_clock_on == $past(dat_i[30]))
		else $error("g1 port clock gates do not follow bits 31 and 30");

	// The g0 port clocks follow bits 27 and 26.
	a_g0_port_clocks: assert property (wr_g && sel_i[3] |=>
		ctrl_g0_o.port1_clock_on == $past(dat_i[27]) && ctrl_g0_o.port0_clock_on == $past(dat_i[26]))
		else $error("g0 port clock gates do not follow bits 27 and 26");

	// The h port clocks follow bits 23 and 22.
	a_h_port_clocks: assert property (wr_g && sel_i[2] |=>
		ctrl_h_o.port1_clock_on == $past(dat_i[23]) && ctrl_h_o.port0_clock_on == $past(dat_i[22]))
		else $error("h port clock gates do not follow bits 23 and 22");

	// The f1 port clocks follow bits 19 and 18.
	a_f1_port_clocks: assert property (wr_g && sel_i[2] |=>
		ctrl_f1_o.port1_clock_on == $past(dat_i[19]) && ctrl_f1_o.port0_clock_on == $past(dat_i[18]))
		else $error("f1 port clock gates do not follow bits 19 and 18");

	// The f0 port 3 clock follows bit 13 and holds while no write hits.
	a_f0_port3_clock: assert property (wr_g && sel_i[1] |=>
		ctrl_f0_port3_clock_on_o == $past(dat_i[13]) ##1 (wr_g || $stable(ctrl_f0_port3_clock_on_o)))
		else $error("f0 port 3 clock gate wrong");

	// Access enables sit at bits 29, 25, 21 and 17.
	a_access_enables: assert property (wr_g && sel_i[3] && sel_i[2] |=>
		ctrl_g1_o.access_on == $past(dat_i[29]) && ctrl_g0_o.access_on == $past(dat_i[25]) &&
		ctrl_h_o.access_on == $past(dat_i[21]) && ctrl_f1_o.access_on == $past(dat_i[17]))
		else $error("controller access enables misplaced");

	// Soft resets sit at bits 28, 24, 20 and 16.
	a_soft_resets: assert property (wr_g && sel_i[3] && sel_i[2] |=>
		ctrl_g1_o.reset_hold == $past(dat_i[28]) && ctrl_g0_o.reset_hold == $past(dat_i[24]) &&
		ctrl_h_o.reset_hold == $past(dat_i[20]) && ctrl_f1_o.reset_hold == $past(dat_i[16]))
		else $error("controller soft resets misplaced");

	// The node is taken from bit 36 plus the source offset.
	a_node_pick: assert property (dma_req_i.valid |=> ht_req_o.valid &&
		ht_req_o.node == 4'(($past(dma_req_i.addr) >> (7'd36 + {2'h0, $past(src_pos)})) & {60'h0, $past(nmask)}))
		else $error("node number taken from the wrong bits");

	// The node lands at bit 32 plus the HT position.
	// Node bits pushed above bit 39 cannot cross the link, so only the bits that fit are compared.
	a_node_place: assert property (dma_req_i.valid |=>
		(ht_req_o.addr & ({36'h0, $past(nmask)} << (dnr_pkg::HT_BASE + {4'h0, $past(ht_pos)}))) ==
		({36'h0, ht_req_o.node} << (dnr_pkg::HT_BASE + {4'h0, $past(ht_pos)})))
		else $error("node number placed at the wrong HT bits");

	// Bits below 32 are never touched, so each node keeps its low range.
	a_low_range_kept: assert property (dma_req_i.valid |=> ht_req_o.addr[31:0] == $past(dma_req_i.addr[31:0]))
		else $error("address bits below the node field changed");

	// A zero mask means one node and an untouched address.
	a_single_node: assert property (dma_req_i.valid && nmask == 4'h0 |=>
		ht_req_o.node == 4'h0 && ht_req_o.addr == $past(dma_req_i.addr[39:0]))
		else $error("zero node mask altered the address");

	// The link follows the per-node bit of the chosen node.
	a_link_select: assert property (dma_req_i.valid |=> ht_req_o.link_sel == $past(pnl[x_node]))
		else $error("link select does not match the per-node bit");

	// Leaving reset, both registers hold their defaults and the bus and DMA outputs are quiet.
	a_reset_defaults: assert property ($fell(rst_i) |-> gcz_q == dnr_pkg::GCZ_RST &&
		xlate_q == dnr_pkg::DMA_XLATE_RST && !ack_o && dat_o == 32'h00000000 && ht_req_o == '0)
		else $error("registers left reset without their default values");

	// Reading the routing register returns what it holds.
	a_read_back_xlate: assert property (s_req_open ##0 (!we_i && hit_x) |=>
		ack_o && dat_o == $past(xlate_q))
		else $error("routing register read returned wrong data");

	// An address that hits neither register reads as zero.
	a_unmapped_read: assert property (s_req_open ##0 (!we_i && !hit_x && !hit_g) |=>
		dat_o == 32'h00000000)
		else $error("unmapped read returned nonzero data");

	// A write to an unmapped address changes neither register.
	a_unmapped_write: assert property (s_write_land ##0 (!hit_x && !hit_g) |=>
		$stable(gcz_q) && $stable(xlate_q))
		else $error("unmapped write disturbed a register");

	// Nothing lands on the edge that takes a request; the master must first see ack.
	a_no_early_write: assert property (s_req_open ##0 we_i |=> $stable(gcz_q) && $stable(xlate_q))
		else $error("write landed before ack was given");

	// Without a landing write the clock gates, access blocks and resets hold still.
	a_config_held: assert property (!wr_g |=> $stable(gcz_q))
		else $error("general config changed without a write");

	// The routing fields change only on a write, so the DMA path sees a steady setup.
	a_route_held: assert property (!wr_x |=> $stable(xlate_q))
		else $error("routing register changed without a write");

	// A full-word write to the routing register is stored as written.
	a_route_write: assert property (s_write_land ##0 (hit_x && sel_i == 4'hf) |=> xlate_q == $past(dat_i))
		else $error("routing register write not stored");

	// A cleared byte enable keeps that byte, here the low one.
	a_byte_kept: assert property (s_write_land ##0 (hit_g && !sel_i[0]) |=> gcz_q[7:0] == $past(gcz_q[7:0]))
		else $error("write changed a byte whose enable was clear");

	// Read data holds between answers, so a slow master still sees the value it asked for.
	a_read_data_held: assert property (!(req && !ack_q) |=> $stable(dat_o))
		else $error("read data changed without a new request");

	// Ack never rises unless a request stood on the edge before.
	a_ack_needs_req: assert property ($rose(ack_o) |-> $past(req))
		else $error("ack rose without a request");

	// An idle input cycle gives an idle output cycle.
	a_dma_idle: assert property (!dma_req_i.valid |=> !ht_req_o.valid)
		else $error("translated request valid without an input request");

	// The node number never has bits outside the mask.
	a_node_in_mask: assert property (dma_req_i.valid |=> (ht_req_o.node & ~$past(nmask)) == 4'h0)
		else $error("node number wider than the node mask");

	// With HT position zero the node occupies bits 35:32 and bits 31:0 stay free for the node.
	a_pos_zero_range: assert property (dma_req_i.valid && ht_pos == 3'h0 |=>
		(ht_req_o.addr[35:32] & $past(nmask)) == ht_req_o.node)
		else $error("node not at bit 32 with HT position zero");

	// A source field that starts above bit 63 finds no node bits at all.
	a_source_beyond: assert property (dma_req_i.valid && src_pos > 5'd27 |=> ht_req_o.node == 4'h0)
		else $error("node found beyond bit 63 of the source address");

endmodule : dnr_cfg_regs

`default_nettype wire

// [rtl/dnr_pkg.sv]
// Package for the DMA node routing and controller configuration block.
// Holds register offsets, field positions, reset values and carrier types.
// Assumes a 16-bit byte address into the bridge configuration space.
package dnr_pkg;

	// Register byte offsets inside the configuration space.
	localparam logic [15:0] DMA_XLATE_OFS = 16'h041c;
	localparam logic [15:0] GCZ_OFS = 16'h0420;

	// Reset values of the two registers.
	localparam logic [31:0] DMA_XLATE_RST = 32'h000aa800;
	localparam logic [31:0] GCZ_RST = 32'hcccc3ce0;

	// Field layout of dma_node_translation.
	localparam int PNL_LSB = 16;
	localparam int PNL_W = 16;
	localparam int HTPOS_LSB = 13;
	localparam int HTPOS_W = 3;
	localparam int SRCPOS_LSB = 8;
	localparam int SRCPOS_W = 5;
	localparam int MASK_LSB = 0;
	localparam int MASK_W = 4;

	// Base bits: source node field counts from bit 36, the HT field from 32.
	localparam logic [6:0] SRC_BASE = 7'h24;
	localparam logic [6:0] HT_BASE = 7'h20;

	// Field layout of general_config_zero: one nibble each for g1, g0, h and f1, and bit 13 for f0 port 3.
	localparam int G1_LSB = 28;
	localparam int G0_LSB = 24;
	localparam int H_LSB = 20;
	localparam int F1_LSB = 16;
	localparam int F0_P3_BIT = 13;

	// A DMA request as issued by a device.
	typedef struct packed {
		logic valid;
		logic [63:0] addr;
	} dnr_dma_req_type;

	// The same request after node translation, headed for an HT link.
	typedef struct packed {
		logic valid;
		logic link_sel;
		logic [3:0] node;
		logic [39:0] addr;
	} dnr_ht_req_type;

	// Controls of one PCIe controller, in register bit order.
	typedef struct packed {
		logic port1_clock_on;
		logic port0_clock_on;
		logic access_on;
		logic reset_hold;
	} dnr_ctrl_type;

endpackage : dnr_pkg

// [verification/testbench.sv]
// Self-checking bench for the DMA node routing and controller configuration registers.
// Assumes the block is driven alone by this bench, over classic Wishbone and the DMA port.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// Stimulus and observed signals.
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ctrl_f0_port3_clock_on_o;
	logic [15:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, rd, gcz, rte, d, s;
	dnr_pkg::dnr_dma_req_type dma_req_i;
	dnr_pkg::dnr_ht_req_type ht_req_o;
	dnr_pkg::dnr_ctrl_type ctrl_g1_o, ctrl_g0_o, ctrl_h_o, ctrl_f1_o;
	logic [45:0] exp_q, exp_d;
	logic [63:0] a;
	logic [31:0] seed;
	logic [3:0] masks [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
	int err_total, checks_done, j, k;

	dnr_cfg_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.dma_req_i(dma_req_i), .ht_req_o(ht_req_o), .ctrl_g1_o(ctrl_g1_o), .ctrl_g0_o(ctrl_g0_o),
		.ctrl_h_o(ctrl_h_o), .ctrl_f1_o(ctrl_f1_o), .ctrl_f0_port3_clock_on_o(ctrl_f0_port3_clock_on_o));

	// Free-running 250 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Shift register source of repeatable random values.
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction : next_rand

	// Byte-lane merge of a write, as the byte enables select.
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
		for (int b = 0; b < 4; b++) begin
			if (m[b]) o[8*b +: 8] = n[8*b +: 8];
		end
		return o;
	endfunction : merge

	// Expected HT request: pull the masked node out, clear it, and drop it in at the HT position.
	function automatic logic [45:0] xlate(input logic [63:0] ad, input logic [31:0] r, input logic v);
		logic [63:0] m;
		logic [63:0] n;
		m = {60'h0, r[3:0]};
		n = (ad >> (36 + r[12:8])) & m;
		ad = ad & ~(m << (36 + r[12:8]));
		ad = (ad & ~(m << (32 + r[15:13]))) | (n << (32 + r[15:13]));
		return {v, r[16 + n[3:0]], n[3:0], ad[39:0]};
	endfunction : xlate

	// One comparison; a mismatch is reported at once.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single Wishbone cycle; read data is taken at the edge where ack is seen.
	task automatic wb(input logic w, input logic [15:0] ad, input logic [31:0] dv, input logic [3:0] m);
		int i;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		sel_i <= m;
		dat_i <= dv;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 20);
		if (ack_o !== 1'b1) begin
			err_total++;
			tally_and_finish();
		end else begin
			rd = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			we_i <= 1'b0;
		end
	endtask : wb

	// Controller outputs must mirror the upper half and bit 13 of the register.
	// The controls change on the edge where the write lands, so they are looked at half a cycle later.
	task automatic ctrl_chk(input logic [31:0] w);
		@(negedge clk_i);
		chk(64'({ctrl_g1_o, ctrl_g0_o, ctrl_h_o, ctrl_f1_o, ctrl_f0_port3_clock_on_o}), 64'({w[31:16], w[13]}));
	endtask : ctrl_chk

	// The single place where the run ends.
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// Main sequence: reset values, register traffic, unmapped access, then DMA translation.
	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
		dma_req_i = '0;
		seed = 32'h05bd8c1b;
		err_total = 0;
		checks_done = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, dnr_pkg::DMA_XLATE_OFS, 32'h0, 4'hf);
		chk(64'(rd), 64'(32'h000aa800));
		wb(1'b0, dnr_pkg::GCZ_OFS, 32'h0, 4'hf);
		chk(64'(rd), 64'(32'hcccc3ce0));
		gcz = 32'hcccc3ce0;
		ctrl_chk(gcz);
		// All-zero and all-one words first, then random data under random byte enables.
		for (k = 0; k < 14; k++) begin
			seed = next_rand(seed);
			d = (k == 0) ? 32'h0 : (k == 1) ? 32'hffffffff : seed;
			seed = next_rand(seed);
			s = (k < 2) ? 32'hf : seed;
			wb(1'b1, dnr_pkg::GCZ_OFS, d, s[3:0]);
			gcz = merge(gcz, d, s[3:0]);
			ctrl_chk(gcz);
			wb(1'b0, dnr_pkg::GCZ_OFS, 32'h0, 4'hf);
			chk(64'(rd), 64'(gcz));
		end
		// An unmapped place reads zero and leaves the general config register as it was.
		wb(1'b1, 16'h0500, 32'hffffffff, 4'hf);
		wb(1'b0, 16'h0500, 32'h0, 4'hf);
		chk(64'(rd), 64'h0);
		wb(1'b0, dnr_pkg::GCZ_OFS, 32'h0, 4'hf);
		chk(64'(rd), 64'(gcz));
		// A second reset in mid-run brings registers, read data and controls back to their defaults.
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk(64'({ack_o, dat_o}), 64'h0);
		wb(1'b0, dnr_pkg::DMA_XLATE_OFS, 32'h0, 4'hf);
		chk(64'(rd), 64'(dnr_pkg::DMA_XLATE_RST));
		wb(1'b0, dnr_pkg::GCZ_OFS, 32'h0, 4'hf);
		chk(64'(rd), 64'(dnr_pkg::GCZ_RST));
		ctrl_chk(dnr_pkg::GCZ_RST);
		// Node masks 0, 1, 3, 7 and f with random or hand-picked positions, eight back-to-back requests, then two idle cycles.
		for (k = 0; k < 5; k++) begin
			seed = next_rand(seed);
			rte = {seed[31:4], masks[k]};
			// Corners: HT position zero, a source field above bit 63, and HT position seven.
			if (k == 1) rte[15:13] = 3'h0;
			if (k == 2) rte[12:8] = 5'h1c;
			if (k == 3) rte[15:8] = {3'h7, 5'h1b};
			wb(1'b1, dnr_pkg::DMA_XLATE_OFS, rte, 4'hf);
			wb(1'b0, dnr_pkg::DMA_XLATE_OFS, 32'h0, 4'hf);
			chk(64'(rd), 64'(rte));
			exp_q = '0;
			for (j = 0; j < 10; j++) begin
				@(posedge clk_i);
				seed = next_rand(seed);
				a[63:32] = seed;
				seed = next_rand(seed);
				a[31:0] = seed;
				dma_req_i <= {j < 8, a};
				exp_d = xlate(a, rte, j < 8);
				@(negedge clk_i);
				if (j > 0) chk(64'(ht_req_o), 64'(exp_q));
				exp_q = exp_d;
			end
		end
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
